// ===== rtl/adc_seq_defs.svh
// Purpose: Register offsets, field positions, reset values and timing for the sequencer
// Assumes: 32-bit AXI4-Lite register space, one aligned word per register
// Notes:   Included by the sequencer module and the testbench
`ifndef ADC_SEQ_DEFS_SVH
`define ADC_SEQ_DEFS_SVH

// ============================================================
// Register byte offsets
`define OFS_CTRL_SECOND   8'h08
`define OFS_CTRL_THIRD    8'h0c
`define OFS_CTRL_FOURTH   8'h10
`define OFS_CTRL_FIFTH    8'h14
`define OFS_STATUS        8'h18
`define OFS_TEST          8'h1c
`define OFS_IRQ_STAT      8'h20
`define OFS_IRQ_MASK      8'h24
`define OFS_RESULT0       8'h40

// ============================================================
// Field positions
`define CTL2_JUSTIFY_BIT  7
`define CTL2_SIGNED_BIT   4
`define CTL2_HALT_BIT     6
`define CTL3_SINGLE_BIT   3
`define CTL3_FIFO_BIT     2
`define CTL5_SEQLEN_BIT   6
`define CTL5_SCAN_BIT     5
`define CTL5_MULT_BIT     4
`define CTL5_IREF_BIT     3
`define TEST_RST_BIT      7
`define STAT_SCF_BIT      7
`define STAT_BUSY_BIT     6
`define IRQ_SCF_BIT       0

// ============================================================
// Reset values and timing
`define RST_CTRL_SECOND   8'h00
`define RST_CTRL_THIRD    8'h00
`define RST_CTRL_FOURTH   8'h01
`define RST_CTRL_FIFTH    8'h00
`define SEQ_LEN_SHORT     4'h4
`define SEQ_LEN_LONG      4'h8
`define SEQ_LEN_ONE       4'h1
`define CONV_TIME_NS      2000
`define CLK_PERIOD_NS     25

`endif

// ===== rtl/adc_seq_pkg.sv
// Purpose: Types shared by the sequencer files
// Assumes: Nothing beyond the defines header
// Notes:   State machine enumeration only
package adc_seq_pkg;

  // ============================================================
  // Sequencer states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_CONV,
    ST_STORE
  } seq_state_e;

endpackage

// ===== rtl/adc_result_mem.sv
// Purpose: Result word storage with registered read data
// Assumes: Single write port, single read port, same clock
// Notes:   Contents are not reset
`timescale 1ns/1ps

module adc_result_mem #(
  parameter int DEPTH = 8,
  parameter int WIDTH = 16
) (
  // Clock
  input  wire logic                     mclk_i,
  // Write side
  input  wire logic                     wr_en_i,
  input  wire logic [$clog2(DEPTH)-1:0] wr_addr_i,
  input  wire logic [WIDTH-1:0]         wr_data_i,
  // Read side
  input  wire logic [$clog2(DEPTH)-1:0] rd_addr_i,
  output logic      [WIDTH-1:0]         rd_data_o
);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [WIDTH-1:0] rd_nxt;

  initial begin
    if (DEPTH < 2 || WIDTH < 1) begin
      $error("adc_result_mem: unsupported parameters");
    end
  end

  // ============================================================
  // Read and write
  always_comb begin
    rd_nxt = mem_r[rd_addr_i];
  end

  always_ff @(posedge mclk_i) begin
    if (wr_en_i) begin
      mem_r[wr_addr_i] <= wr_data_i;
    end
    rd_data_o <= rd_nxt;
  end

endmodule

// ===== rtl/adc_sequence_control.sv
// Purpose: Conversion sequence controller of a APPROXIMATION_VALUE converter with AXI4-Lite registers
// Assumes: Analog comparator answers on comp_i, synchronous to mclk_i
// Notes:   One conversion takes RES_BITS x (CONV_CYC/RES_BITS + 1) + 1 = 91 clocks; 10-bit results
// How it works
// - Channel select bits pick the first channel of a multi-channel sequence, unmasked.
// - Internal-reference bit converts internal references instead of external channels.
// - Writing fourth control register aborts any sequence and starts a new one.
// - Writing second or third control register never aborts a running sequence.
// - Writing fifth control register aborts, clears the complete flag and starts a new sequence.
// - In scan mode the complete flag sets after every sequence.
// - Reading the test register returns the present approximation value.
// - Test register reset bit is writable and resets converter logic.
// - Second control holds justify bit, reset gives legacy alignment; signed option exists.
// - Third control holds FIFO and single-conversion bits, legacy reset values.
// - Sequence length bit selects four or eight; single-conversion bit overrides it.
//
// The AXI4-Lite register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps

`include "adc_seq_defs.svh"

module adc_sequence_control
  import adc_seq_pkg::*;
#(
  parameter int RES_BITS = 10,
  parameter int NUM_CH   = 8
) (
  // Clock and reset
  input  wire logic                      mclk_i,
  input  wire logic                      rst_n_i,
  // AXI4-Lite write
  input  wire logic [7:0]                s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic      [1:0]                s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]                s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic      [31:0]               s_axi_rdata,
  output logic      [1:0]                s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  // Analog front end
  input  wire logic                      comp_i,
  output logic      [$clog2(NUM_CH)-1:0] mux_ch_o,
  output logic                           mux_iref_o,
  output logic      [RES_BITS-1:0]       dac_o,
  output logic                           halt_in_wait_o,
  // Interrupt
  output logic                           irq_o
);

  localparam int CH_W     = $clog2(NUM_CH);
  localparam int CONV_CYC = (`CONV_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam int CNT_W    = $clog2(CONV_CYC + 1);

  initial begin
    if (RES_BITS < 2 || RES_BITS > 16 || NUM_CH != 8) begin
      $error("adc_sequence_control: unsupported parameters");
    end
  end

  // ============================================================
  // Register state
  logic [7:0]          ctrl2_r, ctrl2_nxt;
  logic [7:0]          ctrl3_r, ctrl3_nxt;
  logic [7:0]          ctrl4_r, ctrl4_nxt;
  logic [7:0]          ctrl5_r, ctrl5_nxt;
  logic                scf_r, scf_nxt;
  logic                irq_stat_r, irq_stat_nxt;
  logic                irq_mask_r, irq_mask_nxt;
  logic                aw_held_r, aw_held_nxt;
  logic [7:0]          awaddr_r, awaddr_nxt;
  logic                w_held_r, w_held_nxt;
  logic [31:0]         wdata_r, wdata_nxt;
  logic                bvalid_r, bvalid_nxt;
  logic [1:0]          bresp_r, bresp_nxt;
  logic                rpend_r, rpend_nxt;
  logic [7:0]          raddr_r, raddr_nxt;
  logic                rvalid_r, rvalid_nxt;
  logic [31:0]         rdata_r, rdata_nxt;
  logic                wr_fire, wr_ok;
  logic                start_seq, abort_all;
  logic                seq_done;

  // ============================================================
  // Sequencer state
  seq_state_e          st_r, st_nxt;
  logic [CNT_W-1:0]    cnt_r, cnt_nxt;
  logic [RES_BITS-1:0] sar_r, sar_nxt;
  logic [RES_BITS-1:0] bit_r, bit_nxt;
  logic [3:0]          conv_idx_r, conv_idx_nxt;
  logic [2:0]          fifo_ptr_r, fifo_ptr_nxt;
  logic [3:0]          seq_len;
  logic [2:0]          slot;
  logic [15:0]         result_fmt;
  logic [15:0]         mem_rd;

  // ============================================================
  // AXI4-Lite write path
  always_comb begin
    aw_held_nxt = aw_held_r;
    awaddr_nxt  = awaddr_r;
    w_held_nxt  = w_held_r;
    wdata_nxt   = wdata_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    if (s_axi_awvalid && !aw_held_r) begin
      aw_held_nxt = 1'b1;
      awaddr_nxt  = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_held_r) begin
      w_held_nxt = 1'b1;
      wdata_nxt  = s_axi_wdata;
    end
    if (wr_fire) begin
      aw_held_nxt = 1'b0;
      w_held_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = wr_ok ? 2'h0 : 2'h2;
    end else if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
  end

  assign wr_fire       = aw_held_r && w_held_r && !bvalid_r;
  assign s_axi_awready = !aw_held_r;
  assign s_axi_wready  = !w_held_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign wr_ok = (awaddr_r == `OFS_CTRL_SECOND) || (awaddr_r == `OFS_CTRL_THIRD) ||
                 (awaddr_r == `OFS_CTRL_FOURTH) || (awaddr_r == `OFS_CTRL_FIFTH) ||
                 (awaddr_r == `OFS_TEST) || (awaddr_r == `OFS_IRQ_STAT) ||
                 (awaddr_r == `OFS_IRQ_MASK);

  // Sequence restart and converter reset
  assign start_seq = wr_fire &&
                     ((awaddr_r == `OFS_CTRL_FOURTH) ||
                      (awaddr_r == `OFS_CTRL_FIFTH));
  assign abort_all = wr_fire && (awaddr_r == `OFS_TEST) &&
                     wdata_r[`TEST_RST_BIT];

  // ============================================================
  // Control, status and interrupt registers
  always_comb begin
    ctrl2_nxt    = ctrl2_r;
    ctrl3_nxt    = ctrl3_r;
    ctrl4_nxt    = ctrl4_r;
    ctrl5_nxt    = ctrl5_r;
    scf_nxt      = scf_r;
    irq_stat_nxt = irq_stat_r;
    irq_mask_nxt = irq_mask_r;
    if (wr_fire && s_axi_wstrb[0]) begin
      unique case (awaddr_r)
        `OFS_CTRL_SECOND: ctrl2_nxt = wdata_r[7:0];
        `OFS_CTRL_THIRD:  ctrl3_nxt = wdata_r[7:0];
        `OFS_CTRL_FOURTH: ctrl4_nxt = wdata_r[7:0];
        `OFS_CTRL_FIFTH: begin
          ctrl5_nxt = wdata_r[7:0];
          scf_nxt   = 1'b0;
        end
        `OFS_IRQ_STAT:    irq_stat_nxt = irq_stat_r & ~wdata_r[`IRQ_SCF_BIT];
        `OFS_IRQ_MASK:    irq_mask_nxt = wdata_r[`IRQ_SCF_BIT];
        default: ;
      endcase
    end
    if (abort_all) begin
      scf_nxt = 1'b0;
    end
    if (seq_done) begin
      scf_nxt      = 1'b1;
      irq_stat_nxt = 1'b1;
    end
  end

  assign irq_o          = irq_stat_r & irq_mask_r;
  assign halt_in_wait_o = ctrl2_r[`CTL2_HALT_BIT];

  // ============================================================
  // Sequence length and result slot
  always_comb begin
    seq_len = ctrl5_r[`CTL5_SEQLEN_BIT] ? `SEQ_LEN_LONG : `SEQ_LEN_SHORT;
    if (ctrl3_r[`CTL3_SINGLE_BIT]) begin
      seq_len = `SEQ_LEN_ONE;
    end
    slot = ctrl3_r[`CTL3_FIFO_BIT] ? fifo_ptr_r : conv_idx_r[2:0];
  end

  // Justification and signed formatting
  always_comb begin
    logic [RES_BITS-1:0] v;
    v = sar_r;
    if (ctrl2_r[`CTL2_SIGNED_BIT]) begin
      v[RES_BITS-1] = ~sar_r[RES_BITS-1];
    end
    if (ctrl2_r[`CTL2_JUSTIFY_BIT]) begin
      result_fmt = 16'(v);
      if (ctrl2_r[`CTL2_SIGNED_BIT]) begin
        result_fmt = 16'($signed(v));
      end
    end else begin
      result_fmt = {v, {(16 - RES_BITS){1'b0}}};
    end
  end

  // ============================================================
  // Successive approximation sequencer
  always_comb begin
    st_nxt       = st_r;
    cnt_nxt      = cnt_r;
    sar_nxt      = sar_r;
    bit_nxt      = bit_r;
    conv_idx_nxt = conv_idx_r;
    fifo_ptr_nxt = fifo_ptr_r;
    seq_done     = 1'b0;
    unique case (st_r)
      ST_IDLE: ;
      ST_CONV: begin
        if (cnt_r != CNT_W'(0)) begin
          cnt_nxt = cnt_r - CNT_W'(1);
        end else begin
          if (!comp_i) begin
            sar_nxt = sar_r & ~bit_r;
          end
          bit_nxt = bit_r >> 1;
          if (bit_r[0]) begin
            st_nxt = ST_STORE;
          end else begin
            sar_nxt = (comp_i ? sar_r : sar_r & ~bit_r) | (bit_r >> 1);
            cnt_nxt = CNT_W'(CONV_CYC / RES_BITS);
          end
        end
      end
      ST_STORE: begin
        fifo_ptr_nxt = fifo_ptr_r + 3'h1;
        conv_idx_nxt = conv_idx_r + 4'h1;
        bit_nxt      = {1'b1, {(RES_BITS - 1){1'b0}}};
        sar_nxt      = {1'b1, {(RES_BITS - 1){1'b0}}};
        cnt_nxt      = CNT_W'(CONV_CYC / RES_BITS);
        st_nxt       = ST_CONV;
        if (conv_idx_r + 4'h1 == seq_len) begin
          seq_done     = 1'b1;
          conv_idx_nxt = 4'h0;
          if (!ctrl5_r[`CTL5_SCAN_BIT]) begin
            st_nxt = ST_IDLE;
          end
        end
      end
      default: st_nxt = ST_IDLE;
    endcase
    if (start_seq || abort_all) begin
      conv_idx_nxt = 4'h0;
      fifo_ptr_nxt = abort_all ? 3'h0 : fifo_ptr_nxt;
      bit_nxt      = {1'b1, {(RES_BITS - 1){1'b0}}};
      sar_nxt      = abort_all ? '0 : {1'b1, {(RES_BITS - 1){1'b0}}};
      cnt_nxt      = CNT_W'(CONV_CYC / RES_BITS);
      st_nxt       = abort_all ? ST_IDLE : ST_CONV;
    end
  end

  // Channel on the multiplexer
  always_comb begin
    mux_ch_o = CH_W'(ctrl5_r[2:0]);
    if (ctrl5_r[`CTL5_MULT_BIT]) begin
      mux_ch_o = CH_W'(ctrl5_r[2:0] + conv_idx_r[2:0]);
    end
    mux_iref_o = ctrl5_r[`CTL5_IREF_BIT];
    dac_o      = sar_r;
  end

  adc_result_mem #(
    .DEPTH (8),
    .WIDTH (16)
  ) u_mem (
    .mclk_i    (mclk_i),
    .wr_en_i   (st_r == ST_STORE),
    .wr_addr_i (slot),
    .wr_data_i (result_fmt),
    .rd_addr_i (s_axi_araddr[4:2]),
    .rd_data_o (mem_rd)
  );

  // ============================================================
  // AXI4-Lite read path
  always_comb begin
    rpend_nxt  = rpend_r;
    raddr_nxt  = raddr_r;
    rvalid_nxt = rvalid_r;
    rdata_nxt  = rdata_r;
    if (s_axi_arvalid && s_axi_arready) begin
      rpend_nxt = 1'b1;
      raddr_nxt = s_axi_araddr;
    end
    if (rpend_r) begin
      rpend_nxt  = 1'b0;
      rvalid_nxt = 1'b1;
      rdata_nxt  = 32'h0;
      unique case (raddr_r)
        `OFS_CTRL_SECOND: rdata_nxt[7:0] = ctrl2_r;
        `OFS_CTRL_THIRD:  rdata_nxt[7:0] = ctrl3_r;
        `OFS_CTRL_FOURTH: rdata_nxt[7:0] = ctrl4_r;
        `OFS_CTRL_FIFTH:  rdata_nxt[7:0] = ctrl5_r;
        `OFS_STATUS: begin
          rdata_nxt[`STAT_SCF_BIT]  = scf_r;
          rdata_nxt[`STAT_BUSY_BIT] = (st_r != ST_IDLE);
        end
        `OFS_TEST:        rdata_nxt = 32'(sar_r);
        `OFS_IRQ_STAT:    rdata_nxt[`IRQ_SCF_BIT] = irq_stat_r;
        `OFS_IRQ_MASK:    rdata_nxt[`IRQ_SCF_BIT] = irq_mask_r;
        default: begin
          if (raddr_r[7:5] == 3'(`OFS_RESULT0 >> 5)) begin
            rdata_nxt = 32'(mem_rd);
          end
        end
      endcase
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
  end

  assign s_axi_arready = !rpend_r && !rvalid_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = 2'h0;

  // ============================================================
  // Registers
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl2_r    <= `RST_CTRL_SECOND;
      ctrl3_r    <= `RST_CTRL_THIRD;
      ctrl4_r    <= `RST_CTRL_FOURTH;
      ctrl5_r    <= `RST_CTRL_FIFTH;
      scf_r      <= 1'b0;
      irq_stat_r <= 1'b0;
      irq_mask_r <= 1'b0;
      aw_held_r  <= 1'b0;
      awaddr_r   <= 8'h0;
      w_held_r   <= 1'b0;
      wdata_r    <= 32'h0;
      bvalid_r   <= 1'b0;
      bresp_r    <= 2'h0;
      rpend_r    <= 1'b0;
      raddr_r    <= 8'h0;
      rvalid_r   <= 1'b0;
      rdata_r    <= 32'h0;
      st_r       <= ST_IDLE;
      cnt_r      <= '0;
      sar_r      <= '0;
      bit_r      <= '0;
      conv_idx_r <= 4'h0;
      fifo_ptr_r <= 3'h0;
    end else begin
      ctrl2_r    <= ctrl2_nxt;
      ctrl3_r    <= ctrl3_nxt;
      ctrl4_r    <= ctrl4_nxt;
      ctrl5_r    <= ctrl5_nxt;
      scf_r      <= scf_nxt;
      irq_stat_r <= irq_stat_nxt;
      irq_mask_r <= irq_mask_nxt;
      aw_held_r  <= aw_held_nxt;
      awaddr_r   <= awaddr_nxt;
      w_held_r   <= w_held_nxt;
      wdata_r    <= wdata_nxt;
      bvalid_r   <= bvalid_nxt;
      bresp_r    <= bresp_nxt;
      rpend_r    <= rpend_nxt;
      raddr_r    <= raddr_nxt;
      rvalid_r   <= rvalid_nxt;
      rdata_r    <= rdata_nxt;
      st_r       <= st_nxt;
      cnt_r      <= cnt_nxt;
      sar_r      <= sar_nxt;
      bit_r      <= bit_nxt;
      conv_idx_r <= conv_idx_nxt;
      fifo_ptr_r <= fifo_ptr_nxt;
    end
  end

endmodule

// ===== verif/adc_seq_monitor.sv
// Purpose: Port-level assertions for the sequencer
// Assumes: Bench offers write address and write data in the same cycle
// Notes:   Bound into adc_sequence_control below
`timescale 1ns/1ps

module adc_seq_monitor
  import adc_seq_pkg::*;
#(
  parameter int RES_BITS = 10,
  parameter int NUM_CH   = 8
) (
  // Clock and reset
  input wire logic                      mclk_i,
  input wire logic                      rst_n_i,
  // Write channels
  input wire logic [7:0]                s_axi_awaddr,
  input wire logic                      s_axi_awvalid,
  input wire logic                      s_axi_awready,
  input wire logic [31:0]               s_axi_wdata,
  input wire logic                      s_axi_wvalid,
  input wire logic                      s_axi_wready,
  input wire logic [1:0]                s_axi_bresp,
  input wire logic                      s_axi_bvalid,
  input wire logic                      s_axi_bready,
  // Read channels
  input wire logic [7:0]                s_axi_araddr,
  input wire logic                      s_axi_arvalid,
  input wire logic                      s_axi_arready,
  input wire logic [31:0]               s_axi_rdata,
  input wire logic [1:0]                s_axi_rresp,
  input wire logic                      s_axi_rvalid,
  input wire logic                      s_axi_rready,
  // Front end
  input wire logic [$clog2(NUM_CH)-1:0] mux_ch_o,
  input wire logic                      mux_iref_o,
  input wire logic [RES_BITS-1:0]       dac_o
);

  // ============================================================
  // Helper state
  logic [7:0]          awa_r;
  logic [31:0]         wd_r;
  logic                rd_test_r;

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      awa_r     <= 8'h00;
      wd_r      <= 32'h0;
      rd_test_r <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready) begin
        awa_r <= s_axi_awaddr;
        wd_r  <= s_axi_wdata;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        rd_test_r <= (s_axi_araddr == 8'h1c);
      end
    end
  end

  // ============================================================
  // Assertions
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  sequence wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence ar_take;
    s_axi_arvalid && s_axi_arready;
  endsequence

  write_latency_a: assert property (wr_take |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write response late");
  read_latency_a: assert property (ar_take |=> !s_axi_rvalid ##1 s_axi_rvalid)
    else $error("read data not two cycles after address");
  bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped or changed");
  rresp_okay_a: assert property (s_axi_rvalid |-> s_axi_rresp == 2'b00)
    else $error("read response not okay");
  slverr_resp_a: assert property ($rose(s_axi_bvalid) && awa_r[7:4] == 4'h3 |-> s_axi_bresp == 2'b10)
    else $error("unmapped write not refused");
  okay_resp_a: assert property ($rose(s_axi_bvalid)
    && awa_r inside {8'h08, 8'h0c, 8'h10, 8'h14, 8'h1c, 8'h20, 8'h24}
    |-> s_axi_bresp == 2'b00) else $error("mapped write refused");
  chan_start_a: assert property ($rose(s_axi_bvalid) && awa_r == 8'h14 && !wd_r[3]
    |-> ##[0:2] mux_ch_o == wd_r[$clog2(NUM_CH)-1:0]) else $error("wrong start channel");
  iref_sel_a: assert property ($rose(s_axi_bvalid) && awa_r == 8'h14
    |-> ##[0:2] mux_iref_o == wd_r[3]) else $error("reference select not applied");
  test_reset_a: assert property ($rose(s_axi_bvalid) && awa_r == 8'h1c && wd_r[7]
    |-> ##[0:2] (dac_o == '0) [*4]) else $error("converter not reset");
  test_read_a: assert property ($rose(s_axi_rvalid) && rd_test_r
    |-> s_axi_rdata[RES_BITS-1:0] == $past(dac_o)) else $error("test read differs from approximation");

endmodule

bind adc_sequence_control adc_seq_monitor #(.RES_BITS(RES_BITS), .NUM_CH(NUM_CH)) u_mon (
  .mclk_i, .rst_n_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .mux_ch_o,
  .mux_iref_o, .dac_o);

// ===== verif/testbench.sv
// Purpose: Register-level tests of the conversion sequencer
// Assumes: Comparator held at a fixed level so results are all ones or all zeros
// Notes:   Sequence lengths judged against the measured single-conversion time
`timescale 1ns/1ps
`include "adc_seq_defs.svh"

module testbench
  import adc_seq_pkg::*;
;
  // ============================================================
  // Signals
  logic        mclk_i, rst_n_i, comp_i;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_v;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, mux_iref_o, halt_in_wait_o, irq_o;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic [2:0]  mux_ch_o;
  logic [9:0]  dac_o;
  logic [7:0]  ab_a [4] = '{8'h10, 8'h14, 8'h08, 8'h0c};
  logic [31:0] ab_d [4] = '{32'h1, 32'h51, 32'h0, 32'h0};
  int          t1, t4, t8, n, mismatches, checks;

  always #12.5 mclk_i = ~mclk_i;

  `define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin mismatches++; \
    $display("Error %s expected %0h seen %0h", nm, e, g); end end

  adc_sequence_control u_dut (
    .mclk_i, .rst_n_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .comp_i, .mux_ch_o, .mux_iref_o, .dac_o, .halt_in_wait_o, .irq_o);

  // ============================================================
  // Tasks
  task automatic summarize();
    $display("Counts: checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic timeout(input string what);
    mismatches++;
    $display("Error %s expected answer seen timeout", what);
    summarize();
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge mclk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge mclk_i);
      k++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!(s_axi_bvalid && s_axi_bready) && k < 100);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (k >= 100) timeout("write");
  endtask

  task automatic rd(input logic [7:0] a);
    int k;
    k = 0;
    @(posedge mclk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge mclk_i);
      k++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!(s_axi_rvalid && s_axi_rready) && k < 100);
    rd_v = s_axi_rdata;
    s_axi_rready <= 1'b0;
    if (k >= 100) timeout("read");
  endtask

  task automatic wait_irq();
    n = 0;
    while (irq_o !== 1'b1 && n < 3000) begin
      @(posedge mclk_i);
      n++;
    end
    if (n >= 3000) timeout("irq");
  endtask

  task automatic run(input logic [31:0] c5);
    wr(8'h20, 32'h1);
    wr(8'h14, c5);
    wait_irq();
  endtask

  // ============================================================
  // Main sequence
  initial begin
    mclk_i = 1'b0;
    rst_n_i = 1'b0;
    comp_i = 1'b1;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
    mismatches = 0;
    checks = 0;
    repeat (16) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    rd(8'h08);
    `CHK("ctrl2 reset", {24'h0, `RST_CTRL_SECOND}, rd_v)
    rd(8'h0c);
    `CHK("ctrl3 reset", {24'h0, `RST_CTRL_THIRD}, rd_v)
    rd(8'h10);
    `CHK("ctrl4 reset", {24'h0, `RST_CTRL_FOURTH}, rd_v)
    rd(8'h14);
    `CHK("ctrl5 reset", {24'h0, `RST_CTRL_FIFTH}, rd_v)
    rd(8'h30);
    `CHK("unmapped read", 32'h0, rd_v)
    wr(8'h30, 32'h5);
    `CHK("unmapped write", 2'b10, resp)
    $display("Test reset values done");
    wr(8'h24, 32'h1);
    wr(8'h0c, 32'h8);
    run(32'h05);
    t1 = n;
    rd(8'h40);
    `CHK("left result", 32'h0000ffc0, rd_v)
    rd(8'h1c);
    `CHK("test read idle", {22'h0, dac_o}, rd_v)
    wr(8'h08, 32'hc0);
    `CHK("halt in wait", 1'b1, halt_in_wait_o)
    run(32'h03);
    rd(8'h40);
    `CHK("right result", 32'h000003ff, rd_v)
    wr(8'h08, 32'h10);
    run(32'h08);
    rd(8'h40);
    `CHK("signed result", 32'h00007fc0, rd_v)
    $display("Test justification done");
    wr(8'h0c, 32'h0);
    run(32'h17);
    t4 = n;
    run(32'h51);
    t8 = n;
    `CHK("four long", 1'b1, t4 > 3 * t1 && t4 < 5 * t1)
    `CHK("eight long", 1'b1, t8 > 7 * t1 && t8 < 9 * t1)
    wr(8'h0c, 32'h8);
    run(32'h51);
    `CHK("one long", 1'b1, n < 2 * t1)
    rd(8'h18);
    `CHK("flag set", 1'b1, rd_v[`STAT_SCF_BIT])
    $display("Test lengths done");
    wr(8'h24, 32'h0);
    `CHK("irq masked", 1'b0, irq_o)
    rd(8'h20);
    `CHK("irq status", 1'b1, rd_v[`IRQ_SCF_BIT])
    wr(8'h24, 32'h1);
    `CHK("irq unmasked", 1'b1, irq_o)
    wr(8'h20, 32'h1);
    `CHK("irq cleared", 1'b0, irq_o)
    wr(8'h14, 32'h0);
    rd(8'h18);
    `CHK("flag cleared", 1'b0, rd_v[`STAT_SCF_BIT])
    $display("Test interrupt done");
    wr(8'h0c, 32'h0);
    for (int i = 0; i < 4; i++) begin
      wr(8'h20, 32'h1);
      wr(8'h14, 32'h51);
      repeat (3 * t1) @(posedge mclk_i);
      wr(8'h20, 32'h1);
      wr(ab_a[i], ab_d[i]);
      wait_irq();
      `CHK("restart", i < 2, n > 7 * t1)
    end
    $display("Test abort done");
    wr(8'h0c, 32'h8);
    run(32'h25);
    wr(8'h20, 32'h1);
    wait_irq();
    `CHK("scan repeat", 1'b1, n < 2 * t1)
    wr(8'h1c, 32'h81);
    wr(8'h1c, 32'h0);
    rd(8'h18);
    `CHK("reset flag", 1'b0, rd_v[`STAT_SCF_BIT])
    rd(8'h1c);
    `CHK("test read", 32'h0, rd_v)
    wr(8'h20, 32'h1);
    repeat (3 * t1) @(posedge mclk_i);
    `CHK("scan stopped", 1'b0, irq_o)
    $display("Test scan done");
    wr(8'h0c, 32'hc);
    wr(8'h08, 32'h0);
    wr(8'h1c, 32'h81);
    wr(8'h1c, 32'h0);
    run(32'h01);
    comp_i <= 1'b0;
    run(32'h03);
    rd(8'h40);
    `CHK("fifo first", 32'h0000ffc0, rd_v)
    rd(8'h44);
    `CHK("fifo second", 32'h0, rd_v)
    $display("Test fifo done");
    summarize();
  end

endmodule
